// ### design/tstec_counter.sv
// Byte-addressable error counter with preset, clear and event pulses
`timescale 1ns/1ps
module tstec_counter
  import tstec_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clrHold,
  input wire logic incPulse,
  input wire logic wrLo,
  input wire logic wrHi,
  input wire logic [7:0] wrData,
  output logic [W-1:0] count,
  output logic lsbToggle,
  output logic overflow
);
  logic [W-1:0] count_ff;
  logic [W-1:0] nxt_count;
  logic lsb_ff;
  logic ovf_ff;
  logic doInc;

  assign doInc = incPulse && !clrHold && !wrLo && !wrHi;

  always_comb begin
    nxt_count = count_ff;
    if (clrHold) begin
      nxt_count = '0;
    end else if (wrLo) begin
      nxt_count[7:0] = wrData;
    end else if (wrHi && W > 8) begin
      nxt_count[W-1:W-8] = wrData;
    end else if (doInc) begin
      nxt_count = count_ff + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      count_ff <= '0;
      lsb_ff <= 1'b0;
      ovf_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      lsb_ff <= doInc;
      ovf_ff <= doInc && (&count_ff);
    end
  end

  assign count = count_ff;
  assign lsbToggle = lsb_ff;
  assign overflow = ovf_ff;
endmodule : tstec_counter

// ### design/tstec_prbs.sv
// Byte-wide 2^15-1 sequence generator and self-synchronising checker
`timescale 1ns/1ps
module tstec_prbs
  import tstec_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic genStep,
  input wire logic chkStep,
  input wire logic [7:0] chkByte,
  output logic [7:0] genByte,
  output logic chkErr
);
  logic [14:0] gen_ff;
  logic [14:0] chk_ff;
  logic [7:0] genOut;
  logic [14:0] genNext;
  logic [14:0] chkNext;
  logic chkMiss;

  // Generator and checker share the x^15 + x^14 + 1 feedback, MSB first
  always_comb begin
    genNext = gen_ff;
    chkNext = chk_ff;
    genOut = 8'h00;
    chkMiss = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      genOut[i] = genNext[14] ^ genNext[13];
      genNext = {genNext[13:0], genOut[i]};
      chkMiss = chkMiss | ((chkNext[14] ^ chkNext[13]) != chkByte[i]);
      chkNext = {chkNext[13:0], chkByte[i]};
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      gen_ff <= PRBS_SEED;
      chk_ff <= PRBS_SEED;
    end else begin
      if (genStep) begin
        gen_ff <= genNext;
      end
      if (chkStep) begin
        chk_ff <= chkNext;
      end
    end
  end

  assign genByte = genOut;
  assign chkErr = chkStep && chkMiss;
endmodule : tstec_prbs

// ### design/tstec_top.sv
// Timeslot test, error insertion and error counter logic of the framer
// Operation
// [R1] Without excess-zero enable, count only real violations
// [R2] With enable, also count excess-zero runs
// [R3] Sixteen-bit violation counter, one per violation
// [R4] Software writes low byte before high byte
// [R5] Pause bit halts violation count while unframed
// [R6] E1 violation single and overflow events
// [R7] Sixteen-bit CRC-4 counter, one per error
// [R8] CRC-4 single and overflow events
// [R9] Eight-bit PRBS error counter with overflow event
// [R10] Multiframe counter loadable, cleared by PRBS write
// [R11] T1 error insertion; forced loss beats coding
// [R12] E1 error insertion; forced loss beats coding
// [R13] One control byte per channel, 24/32
// [R14] T1 clear channel disables bit robbing
// [R15] Signaling source microport or backplane input
// [R16] Local loop: backplane input to backplane output
// [R17] Remote loop: line receive to line transmit
// [R18] Software never sets both loops together
// [R19] Sequence zero: PRBS transmit and checking
// [R20] Sequence one: milliwatt transmit and receive replace
// [R21] Inversion of transmit and receive channel data
// [R22] Message byte replaces transmit channel data
// [R23] Counter clear bit holds all counters zero
// [R24] Unmasked event latches bit, drives request low
// [R25] Milliwatt bytes cycle one per frame
// [R26] Eight-bit counters wrap with overflow event
`timescale 1ns/1ps
module tstec_top
  import tstec_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [3:0] cpuPage,
  input wire logic [4:0] cpuAddr,
  input wire logic [7:0] cpuWrData,
  input wire logic cpuWrEn,
  input wire logic cpuRdEn,
  output logic [7:0] cpuRdData,
  input wire logic e1Mode,
  input wire logic hdb3Coding,
  input wire logic termSyncLost,
  input wire logic rxBitValid,
  input wire logic rxBit,
  input wire logic rxViolation,
  input wire logic crcErrEvent,
  input wire logic rxMultiframe,
  input wire logic frameStart,
  input wire logic chanStrobe,
  input wire logic [4:0] chanNum,
  input wire logic robFrame,
  input wire logic robBit,
  input wire logic [7:0] lineRxByte,
  input wire logic [7:0] backplaneTransmitInput,
  input wire logic [3:0] backplaneSignalingInput,
  output logic [7:0] lineTxByte,
  output logic [7:0] backplaneReceiveOutput,
  output logic [3:0] txSignaling,
  output logic chanOutValid,
  output logic forceBipolarViolation,
  output logic forceCrcError,
  output logic forceTerminalFramingBitError,
  output logic forceSignalingFramingBitError,
  output logic forceAlignmentWordError,
  output logic forceNonAlignmentWordError,
  output logic forceSignalLoss,
  output logic txCodingEnable,
  output logic irqN
);
  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [3:0] pg, input logic [4:0] ofs, input logic [3:0] cp,
                               input logic [4:0] ca);
    return (cp == pg) && (ca == ofs);
  endfunction : hit

  logic [7:0] chanCtrl_ff [NUM_CHAN];
  logic [3:0] sigStore_ff [NUM_CHAN];
  logic [7:0] lineCfg_ff, seqCfg_ff, msgByte_ff, errIns_ff, resetCtrl_ff, evtMask_ff;
  logic [5:0] evtLatch_ff;
  logic [7:0] rdData_ff;
  logic irqN_ff;
  logic [4:0] zeroRun_ff;
  logic [2:0] mwIdx_ff;
  logic [7:0] lineTx_ff, bpRx_ff;
  logic [3:0] txSig_ff;
  logic chanValid_ff;
  logic [7:0] forceOut_ff;

  logic wrPrbs, wrMf, wrLcvA, wrLcvB, wrCrcA, wrCrcB, rdLatch;
  logic chanPage, sigPage;
  logic [4:0] cpuChan;
  assign wrPrbs = cpuWrEn && hit(PG_COUNT, OFS_PRBS_ERR, cpuPage, cpuAddr);
  assign wrMf = cpuWrEn && hit(PG_COUNT, OFS_PRBS_MF, cpuPage, cpuAddr);
  assign wrLcvA = cpuWrEn && hit(PG_COUNT, OFS_LCV_A, cpuPage, cpuAddr);
  assign wrLcvB = cpuWrEn && hit(PG_COUNT, OFS_LCV_B, cpuPage, cpuAddr);
  assign wrCrcA = cpuWrEn && hit(PG_COUNT, OFS_CRC_A, cpuPage, cpuAddr);
  assign wrCrcB = cpuWrEn && hit(PG_COUNT, OFS_CRC_B, cpuPage, cpuAddr);
  assign rdLatch = cpuRdEn && hit(PG_COUNT, OFS_EVT_LATCH, cpuPage, cpuAddr);
  assign chanPage = ((cpuPage == PG_CHAN_LO) || (cpuPage == PG_CHAN_HI)) && !cpuAddr[4];
  assign sigPage = ((cpuPage == PG_SIG_LO) || (cpuPage == PG_SIG_HI)) && !cpuAddr[4];
  assign cpuChan = {cpuPage == PG_CHAN_HI || cpuPage == PG_SIG_HI, cpuAddr[3:0]};

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lineCfg_ff <= RST_BYTE;
      seqCfg_ff <= RST_BYTE;
      msgByte_ff <= RST_BYTE;
      errIns_ff <= RST_BYTE;
      resetCtrl_ff <= RST_BYTE;
      evtMask_ff <= RST_BYTE;
    end else if (cpuWrEn && cpuPage == PG_CTRL) begin
      if (cpuAddr == OFS_LINE_CFG) lineCfg_ff <= cpuWrData;
      if (cpuAddr == OFS_SEQ_CFG) seqCfg_ff <= cpuWrData;
      if (cpuAddr == OFS_MSG_BYTE) msgByte_ff <= cpuWrData;
      if (cpuAddr == OFS_ERR_INS) errIns_ff <= cpuWrData;
      if (cpuAddr == OFS_RESET_CTRL) resetCtrl_ff <= cpuWrData;
      if (cpuAddr == OFS_EVT_MASK) evtMask_ff <= cpuWrData;
    end
  end

  // One control byte and one signaling nibble per channel
  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++) begin : gChan
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          chanCtrl_ff[g] <= RST_BYTE;
          sigStore_ff[g] <= 4'h0;
        end else begin
          if (cpuWrEn && chanPage && cpuChan == 5'(g)) chanCtrl_ff[g] <= cpuWrData; // R13
          if (cpuWrEn && sigPage && cpuChan == 5'(g)) sigStore_ff[g] <= cpuWrData[3:0];
        end
      end
    end
  endgenerate

  logic exzEn, oofPause, cntClear, seqMw;
  assign exzEn = lineCfg_ff[BIT_EXZ_EN];
  assign oofPause = resetCtrl_ff[BIT_OOF_PAUSE];
  assign cntClear = resetCtrl_ff[BIT_CNT_CLEAR];
  assign seqMw = seqCfg_ff[BIT_SEQ_SEL];

  // ----------------------------------------------------------------
  // Excess-zero detection and counters
  // ----------------------------------------------------------------
  logic [3:0] zeroLimit;
  logic exzEvent, lcvInc;
  assign zeroLimit = hdb3Coding ? ZERO_LIMIT_HDB3 : ZERO_LIMIT_PLAIN;
  // One event per run, on the first zero past the limit
  assign exzEvent = rxBitValid && !rxBit && (zeroRun_ff == {1'b0, zeroLimit}); // R2
  assign lcvInc = (rxViolation || (exzEn && exzEvent)) && !(oofPause && termSyncLost); // R1 R5

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      zeroRun_ff <= 5'h00;
    end else if (rxBitValid) begin
      // Saturate above the longest limit so a long run fires once
      zeroRun_ff <= rxBit ? 5'h00 : (zeroRun_ff[4] ? zeroRun_ff : zeroRun_ff + 5'h01);
    end
  end

  logic [15:0] lcvCount, crcCount;
  logic [7:0] prbsCount, mfCount;
  logic lcvOne, lcvOvf, crcOne, crcOvf, prbsOvf, mfOvf, prbsErr;

  tstec_counter #(.W(16)) uLcv ( // R3 R23
    .clk_sys(clk_sys), .nrst(nrst), .clrHold(cntClear), .incPulse(lcvInc), .wrLo(wrLcvA), .wrHi(wrLcvB),
    .wrData(cpuWrData), .count(lcvCount), .lsbToggle(lcvOne), .overflow(lcvOvf));
  tstec_counter #(.W(16)) uCrc ( // R7 R23
    .clk_sys(clk_sys), .nrst(nrst), .clrHold(cntClear), .incPulse(crcErrEvent && e1Mode), .wrLo(wrCrcA),
    .wrHi(wrCrcB), .wrData(cpuWrData), .count(crcCount), .lsbToggle(crcOne), .overflow(crcOvf));
  tstec_counter #(.W(8)) uPrbs ( // R9 R26
    .clk_sys(clk_sys), .nrst(nrst), .clrHold(cntClear), .incPulse(prbsErr), .wrLo(wrPrbs), .wrHi(1'b0),
    .wrData(cpuWrData), .count(prbsCount), .lsbToggle(), .overflow(prbsOvf));
  tstec_counter #(.W(8)) uMf ( // R10 R26
    .clk_sys(clk_sys), .nrst(nrst), .clrHold(cntClear || wrPrbs), .incPulse(rxMultiframe), .wrLo(wrMf),
    .wrHi(1'b0), .wrData(cpuWrData), .count(mfCount), .lsbToggle(), .overflow(mfOvf));

  // ----------------------------------------------------------------
  // Event latch and request
  // ----------------------------------------------------------------
  logic [5:0] evtRaw, nxt_evtLatch;
  assign evtRaw = {mfOvf, prbsOvf, crcOvf, crcOne, lcvOvf && e1Mode, lcvOne && e1Mode}; // R6 R8 R9
  // A new event wins over the clear-on-read
  assign nxt_evtLatch = (rdLatch ? 6'h00 : evtLatch_ff) | (evtRaw & evtMask_ff[5:0]); // R24

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      evtLatch_ff <= 6'h00;
      irqN_ff <= 1'b1;
    end else begin
      evtLatch_ff <= nxt_evtLatch;
      irqN_ff <= ~(|nxt_evtLatch); // R24
    end
  end

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  logic [7:0] rdMux;
  always_comb begin
    rdMux = 8'h00;
    if (chanPage) begin
      rdMux = chanCtrl_ff[cpuChan];
    end else if (sigPage) begin
      rdMux = {4'h0, sigStore_ff[cpuChan]};
    end else if (cpuPage == PG_COUNT) begin
      unique case (cpuAddr)
        OFS_PRBS_ERR: rdMux = prbsCount;
        OFS_PRBS_MF: rdMux = mfCount;
        OFS_LCV_A: rdMux = lcvCount[7:0];
        OFS_LCV_B: rdMux = lcvCount[15:8];
        OFS_CRC_A: rdMux = crcCount[7:0];
        OFS_CRC_B: rdMux = crcCount[15:8];
        OFS_EVT_LATCH: rdMux = {2'b00, evtLatch_ff};
        default: rdMux = 8'h00;
      endcase
    end else if (cpuPage == PG_CTRL) begin
      unique case (cpuAddr)
        OFS_LINE_CFG: rdMux = lineCfg_ff;
        OFS_SEQ_CFG: rdMux = seqCfg_ff;
        OFS_MSG_BYTE: rdMux = msgByte_ff;
        OFS_ERR_INS: rdMux = errIns_ff;
        OFS_RESET_CTRL: rdMux = resetCtrl_ff;
        OFS_EVT_MASK: rdMux = evtMask_ff;
        default: rdMux = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdData_ff <= 8'h00;
    end else if (cpuRdEn) begin
      rdData_ff <= rdMux;
    end
  end

  // ----------------------------------------------------------------
  // Per-channel datapath
  // ----------------------------------------------------------------
  logic [7:0] ctl, prbsByte, mwByte, txSel, rxSel;
  logic chanOk, txTest, rxTest, robOn;
  assign chanOk = chanStrobe && (e1Mode || chanNum < T1_CHANNELS);
  assign ctl = chanCtrl_ff[chanNum];
  assign txTest = chanOk && ctl[PC_TX_TEST];
  assign rxTest = chanOk && ctl[PC_RX_TEST];

  tstec_prbs uSeq (
    .clk_sys(clk_sys), .nrst(nrst), .genStep(txTest && !seqMw), .chkStep(rxTest && !seqMw), // R19
    .chkByte(lineRxByte), .genByte(prbsByte), .chkErr(prbsErr));

  assign mwByte = e1Mode ? MW_E1[mwIdx_ff] : MW_T1[mwIdx_ff]; // R25
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mwIdx_ff <= 3'd0;
    end else if (frameStart) begin
      mwIdx_ff <= (mwIdx_ff >= (e1Mode ? MW_LEN_E1 : MW_LEN_T1)) ? 3'd0 : mwIdx_ff + 3'd1; // R25
    end
  end

  // Transmit: loop, test, message, inversion, payload error, forced loss
  always_comb begin
    txSel = ctl[PC_REMOTE_LB] ? lineRxByte : backplaneTransmitInput; // R17
    if (ctl[PC_TX_TEST]) txSel = seqMw ? mwByte : prbsByte; // R19 R20
    if (ctl[PC_MSG]) txSel = msgByte_ff; // R22
    if (ctl[PC_INVERT]) txSel = ~txSel; // R21
    if (errIns_ff[EI_PAYLOAD]) txSel[0] = ~txSel[0]; // R11 R12
    if (errIns_ff[EI_LOSS]) txSel = 8'h00; // R11 R12
  end

  // Backplane receive: loop, milliwatt replace, inversion
  always_comb begin
    rxSel = ctl[PC_LOCAL_LB] ? backplaneTransmitInput : lineRxByte; // R16
    if (ctl[PC_RX_TEST] && seqMw) rxSel = mwByte; // R20
    if (ctl[PC_INVERT]) rxSel = ~rxSel; // R21
  end

  assign robOn = !e1Mode && !ctl[PC_NO_ROB] && robFrame; // R14

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lineTx_ff <= 8'h00;
      bpRx_ff <= 8'h00;
      txSig_ff <= 4'h0;
      chanValid_ff <= 1'b0;
    end else begin
      chanValid_ff <= chanOk;
      if (chanOk) begin
        lineTx_ff <= (robOn && !errIns_ff[EI_LOSS]) ? {txSel[7:1], robBit} : txSel; // R14
        bpRx_ff <= rxSel;
        txSig_ff <= ctl[PC_SIG_UP] ? sigStore_ff[chanNum] : backplaneSignalingInput; // R15
      end
    end
  end

  // ----------------------------------------------------------------
  // Error insertion outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      forceOut_ff <= 8'h80;
    end else begin
      forceOut_ff <= {~errIns_ff[EI_LOSS], errIns_ff[EI_LOSS], // R11 R12
                      errIns_ff[EI_FRM2] && e1Mode, errIns_ff[EI_FRM1] && e1Mode,
                      errIns_ff[EI_FRM2] && !e1Mode, errIns_ff[EI_FRM1] && !e1Mode,
                      errIns_ff[EI_CRC], errIns_ff[EI_BPV]};
    end
  end

  assign forceBipolarViolation = forceOut_ff[0];
  assign forceCrcError = forceOut_ff[1];
  assign forceTerminalFramingBitError = forceOut_ff[2];
  assign forceSignalingFramingBitError = forceOut_ff[3];
  assign forceAlignmentWordError = forceOut_ff[4];
  assign forceNonAlignmentWordError = forceOut_ff[5];
  assign forceSignalLoss = forceOut_ff[6];
  assign txCodingEnable = forceOut_ff[7];
  assign cpuRdData = rdData_ff;
  assign lineTxByte = lineTx_ff;
  assign backplaneReceiveOutput = bpRx_ff;
  assign txSignaling = txSig_ff;
  assign chanOutValid = chanValid_ff;
  assign irqN = irqN_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_lcv_step: assert property (lcvInc && !cntClear && !wrLcvA && !wrLcvB |=> // R3
    lcvCount == $past(lcvCount) + 16'h0001) else $error("violation count did not step by one");
  a_lcv_pause: assert property (oofPause && termSyncLost && !cntClear && !wrLcvA && !wrLcvB |=> // R5
    $stable(lcvCount)) else $error("violation count moved while paused");
  a_exz_gate: assert property (!exzEn && !rxViolation && !cntClear && !wrLcvA && !wrLcvB |=> // R1
    $stable(lcvCount)) else $error("excess zeros counted while disabled");
  a_clear_hold: assert property (cntClear[*2] |-> lcvCount == 16'h0000 && crcCount == 16'h0000 && // R23
    prbsCount == 8'h00 && mfCount == 8'h00) else $error("counters not held at zero");
  a_mf_clear: assert property (wrPrbs && !cntClear |=> mfCount == 8'h00) // R10
    else $error("multiframe count not cleared by error count write");
  a_crc_event: assert property (crcErrEvent && e1Mode && !cntClear && !wrCrcA && !wrCrcB && evtMask_ff[EV_CRC_ONE]
    |-> ##2 evtLatch_ff[EV_CRC_ONE] && !irqN) else $error("crc event not latched"); // R8
  a_irq_level: assert property (irqN == (evtLatch_ff == 6'h00)) // R24
    else $error("request level disagrees with latch");
  a_remote_loop: assert property (chanOk && ctl[PC_REMOTE_LB] && ctl[7:3] == 5'b00100 && !errIns_ff[EI_LOSS] &&
    !errIns_ff[EI_PAYLOAD] && !robOn |=> lineTxByte == $past(lineRxByte)) // R17
    else $error("remote loop data mismatch");
  a_local_loop: assert property (chanOk && ctl[PC_LOCAL_LB] && !ctl[PC_INVERT] && !ctl[PC_RX_TEST] |=> // R16
    backplaneReceiveOutput == $past(backplaneTransmitInput)) else $error("local loop data mismatch");
  a_msg_insert: assert property (chanOk && ctl[PC_MSG] && !ctl[PC_INVERT] && errIns_ff[5:4] == 2'b00 && !robOn |=>
    lineTxByte == $past(msgByte_ff)) else $error("message byte not sent"); // R22
  a_loss_force: assert property (chanOk && errIns_ff[EI_LOSS] |=> lineTxByte == 8'h00 && !txCodingEnable) // R11
    else $error("forced loss not applied");

  c_lcv_wrap: cover property (lcvOvf);
  c_prbs_err: cover property (prbsErr);
  c_mw_tx: cover property (txTest && seqMw);
  c_irq: cover property (!irqN ##1 rdLatch ##2 irqN);
endmodule : tstec_top

// ### inc/tstec_pkg.sv
// Constants for the timeslot test and error counter block
package tstec_pkg;
  // ----------------------------------------------------------------
  // Register pages
  // ----------------------------------------------------------------
  localparam logic [3:0] PG_CTRL = 4'h1;
  localparam logic [3:0] PG_COUNT = 4'h4;
  localparam logic [3:0] PG_SIG_LO = 4'h5;
  localparam logic [3:0] PG_SIG_HI = 4'h6;
  localparam logic [3:0] PG_CHAN_LO = 4'hA;
  localparam logic [3:0] PG_CHAN_HI = 4'hB;
  // ----------------------------------------------------------------
  // Offsets on the counter page
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_PRBS_ERR = 5'h10;
  localparam logic [4:0] OFS_PRBS_MF = 5'h11;
  localparam logic [4:0] OFS_LCV_A = 5'h16;
  localparam logic [4:0] OFS_LCV_B = 5'h17;
  localparam logic [4:0] OFS_CRC_A = 5'h18;
  localparam logic [4:0] OFS_CRC_B = 5'h19;
  localparam logic [4:0] OFS_EVT_LATCH = 5'h1F;
  // ----------------------------------------------------------------
  // Offsets on the control page
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_LINE_CFG = 5'h12;
  localparam logic [4:0] OFS_SEQ_CFG = 5'h13;
  localparam logic [4:0] OFS_MSG_BYTE = 5'h14;
  localparam logic [4:0] OFS_ERR_INS = 5'h19;
  localparam logic [4:0] OFS_RESET_CTRL = 5'h1A;
  localparam logic [4:0] OFS_EVT_MASK = 5'h1D;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_EXZ_EN = 5;
  localparam int BIT_OOF_PAUSE = 2;
  localparam int BIT_CNT_CLEAR = 4;
  localparam int BIT_SEQ_SEL = 0;
  localparam int EI_BPV = 0;
  localparam int EI_CRC = 1;
  localparam int EI_FRM1 = 2;
  localparam int EI_FRM2 = 3;
  localparam int EI_PAYLOAD = 4;
  localparam int EI_LOSS = 5;
  localparam int PC_NO_ROB = 0;
  localparam int PC_SIG_UP = 1;
  localparam int PC_RX_TEST = 2;
  localparam int PC_TX_TEST = 3;
  localparam int PC_LOCAL_LB = 4;
  localparam int PC_REMOTE_LB = 5;
  localparam int PC_INVERT = 6;
  localparam int PC_MSG = 7;
  localparam int EV_LCV_ONE = 0;
  localparam int EV_LCV_OVF = 1;
  localparam int EV_CRC_ONE = 2;
  localparam int EV_CRC_OVF = 3;
  localparam int EV_PRBS_OVF = 4;
  localparam int EV_MF_OVF = 5;
  // ----------------------------------------------------------------
  // Counts, sizes and reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] T1_CHANNELS = 5'd24;
  localparam int NUM_CHAN = 32;
  localparam logic [3:0] ZERO_LIMIT_HDB3 = 4'd3;
  localparam logic [3:0] ZERO_LIMIT_PLAIN = 4'd15;
  localparam logic [14:0] PRBS_SEED = 15'h7fff;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] MW_LEN_T1 = 3'd7;
  localparam logic [2:0] MW_LEN_E1 = 3'd6;
  localparam logic [7:0] MW_T1 [8] = '{8'h1e, 8'h0b, 8'h0b, 8'h1e, 8'h9e, 8'h8b, 8'h8b, 8'h9e};
  localparam logic [7:0] MW_E1 [8] = '{8'h34, 8'h21, 8'h21, 8'h34, 8'hb4, 8'ha1, 8'hb1, 8'h00};
endpackage : tstec_pkg

// ### verif/testbench.sv
// Self-checking bench for the timeslot test and error counter block
`timescale 1ns/1ps
module testbench;
  import tstec_pkg::*;
  logic clk_sys, nrst, cpuWrEn, cpuRdEn, e1Mode, hdb3Coding, termSyncLost, crcErrEvent, robFrame, rxBitValid, rxBit;
  logic chanStrobe, rxViolation, rxMultiframe, chanOutValid, forceSignalLoss, txCodingEnable, irqN;
  logic [3:0] cpuPage;
  logic [4:0] cpuAddr, chanNum;
  logic [7:0] cpuWrData, cpuRdData, lineRxByte, bpIn, lineTxByte, bpOut;
  int errCount = 0;
  int nCompared = 0;
  localparam logic [7:0] CTL [5] = '{8'h80, 8'h20, 8'h10, 8'h50, 8'hC0};
  localparam logic [7:0] EXPV [5] = '{8'h5A, 8'h3C, 8'hC3, 8'h3C, 8'hA5};
  tstec_top u_dut (.clk_sys(clk_sys), .nrst(nrst), .cpuPage(cpuPage), .cpuAddr(cpuAddr), .cpuWrData(cpuWrData),
    .cpuWrEn(cpuWrEn), .cpuRdEn(cpuRdEn), .cpuRdData(cpuRdData), .e1Mode(e1Mode), .hdb3Coding(hdb3Coding),
    .termSyncLost(termSyncLost), .rxBitValid(rxBitValid), .rxBit(rxBit), .rxViolation(rxViolation),
    .crcErrEvent(crcErrEvent), .rxMultiframe(rxMultiframe), .frameStart(1'b0), .chanStrobe(chanStrobe),
    .chanNum(chanNum), .robFrame(robFrame), .robBit(1'b0), .lineRxByte(lineRxByte), .backplaneTransmitInput(bpIn),
    .backplaneSignalingInput(4'h0), .lineTxByte(lineTxByte), .backplaneReceiveOutput(bpOut), .txSignaling(),
    .chanOutValid(chanOutValid), .forceBipolarViolation(), .forceCrcError(), .forceTerminalFramingBitError(),
    .forceSignalingFramingBitError(), .forceAlignmentWordError(), .forceNonAlignmentWordError(),
    .forceSignalLoss(forceSignalLoss), .txCodingEnable(txCodingEnable), .irqN(irqN));
  tstec_far_model u_far (.clk_sys(clk_sys), .chanStrobe(chanStrobe), .chanNum(chanNum), .lineRxByte(lineRxByte),
    .backplaneTransmitInput(bpIn), .rxViolation(rxViolation), .rxMultiframe(rxMultiframe));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic closeOut();
    $display("compared %0d, mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : closeOut
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    nCompared++;
    if (got !== exp) begin
      errCount++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] pg, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    {cpuPage, cpuAddr, cpuWrData, cpuWrEn} <= {pg, a, d, 1'b1};
    @(posedge clk_sys);
    cpuWrEn <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] pg, input logic [4:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_sys);
    {cpuPage, cpuAddr, cpuRdEn} <= {pg, a, 1'b1};
    @(posedge clk_sys);
    cpuRdEn <= 1'b0;
    #1 chk(what, exp, cpuRdData);
  endtask : rd
  task automatic t_lcv();
    wr(PG_CTRL, OFS_EVT_MASK, 8'h07);
    wr(PG_COUNT, OFS_LCV_A, 8'hFF);
    wr(PG_COUNT, OFS_LCV_B, 8'hFF);
    u_far.pulse(1'b0, 1);
    repeat (3) @(posedge clk_sys);
    #1 chk("irqN", 8'h00, {7'h0, irqN});
    rd(PG_COUNT, OFS_LCV_A, 8'h00, "lcv low");
    rd(PG_COUNT, OFS_LCV_B, 8'h00, "lcv high");
    rd(PG_COUNT, OFS_EVT_LATCH, 8'h03, "events");
    rd(PG_COUNT, OFS_EVT_LATCH, 8'h00, "events cleared");
    wr(PG_CTRL, OFS_LINE_CFG, 8'h20);
    {rxBitValid, rxBit} <= 2'b10;
    repeat (20) @(posedge clk_sys);
    rxBitValid <= 1'b0;
    rd(PG_COUNT, OFS_LCV_A, 8'h01, "excess zeros");
  endtask : t_lcv
  task automatic t_clr();
    u_far.pulse(1'b0, 2);
    wr(PG_CTRL, OFS_RESET_CTRL, 8'h10);
    u_far.pulse(1'b0, 1);
    rd(PG_COUNT, OFS_LCV_A, 8'h00, "lcv held");
    wr(PG_CTRL, OFS_RESET_CTRL, 8'h04);
    u_far.pulse(1'b0, 1);
    termSyncLost <= 1'b1;
    u_far.pulse(1'b0, 2);
    rd(PG_COUNT, OFS_LCV_A, 8'h01, "lcv paused");
  endtask : t_clr
  task automatic t_prbs();
    u_far.pulse(1'b1, 3);
    rd(PG_COUNT, OFS_PRBS_MF, 8'h03, "multiframes");
    wr(PG_COUNT, OFS_PRBS_ERR, 8'h05);
    rd(PG_COUNT, OFS_PRBS_ERR, 8'h05, "prbs errors");
    rd(PG_COUNT, OFS_PRBS_MF, 8'h00, "multiframes cleared");
    crcErrEvent <= 1'b1;
    @(posedge clk_sys);
    crcErrEvent <= 1'b0;
    rd(PG_COUNT, OFS_CRC_A, 8'h01, "crc4 low");
  endtask : t_prbs
  task automatic t_ins();
    wr(PG_CTRL, OFS_ERR_INS, 8'h20);
    repeat (2) @(posedge clk_sys);
    #1 chk("loss", 8'h01, {7'h0, forceSignalLoss});
    chk("coding", 8'h00, {7'h0, txCodingEnable});
    u_far.send(5'h03, 8'h3C, 8'hC3);
    chk("loss byte", 8'h00, lineTxByte);
    wr(PG_CTRL, OFS_ERR_INS, 8'h00);
  endtask : t_ins
  task automatic t_chan();
    wr(PG_CTRL, OFS_MSG_BYTE, 8'h5A);
    for (int i = 0; i < 5; i++) begin
      wr(PG_CHAN_LO, 5'h03, CTL[i]);
      u_far.send(5'h03, 8'h3C, 8'hC3);
      chk("valid", 8'h01, {7'h0, chanOutValid});
      chk("channel byte", EXPV[i], (i == 2 || i == 3) ? bpOut : lineTxByte);
    end
    wr(PG_CTRL, OFS_SEQ_CFG, 8'h01);
    wr(PG_CHAN_LO, 5'h03, 8'h04);
    u_far.send(5'h03, 8'h3C, 8'hC3);
    chk("milliwatt", MW_E1[0], bpOut);
    wr(PG_CHAN_HI, 5'h09, 8'h80);
    e1Mode <= 1'b0;
    u_far.send(5'h19, 8'h3C, 8'hC3);
    chk("refused channel", 8'h00, {7'h0, chanOutValid});
  endtask : t_chan
  initial begin
    {nrst, cpuWrEn, cpuRdEn, termSyncLost, crcErrEvent, robFrame, rxBitValid, rxBit, cpuPage, cpuAddr, cpuWrData} = '0;
    {e1Mode, hdb3Coding} = 2'b11;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    t_lcv();
    t_clr();
    t_prbs();
    t_ins();
    t_chan();
    closeOut();
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    errCount++;
    closeOut();
  end
endmodule : testbench

// ### verif/tstec_far_model.sv
// Far-side model: line terminal events and backplane channel stream
`timescale 1ns/1ps
module tstec_far_model (
  input wire logic clk_sys,
  output logic chanStrobe,
  output logic [4:0] chanNum,
  output logic [7:0] lineRxByte,
  output logic [7:0] backplaneTransmitInput,
  output logic rxViolation,
  output logic rxMultiframe
);
  initial begin
    {chanStrobe, chanNum, lineRxByte, backplaneTransmitInput, rxViolation, rxMultiframe} = '0;
  end
  // One-cycle event pulses, back to back
  task automatic pulse(input bit mf, input int k);
    repeat (k) begin
      @(posedge clk_sys);
      {rxMultiframe, rxViolation} <= mf ? 2'b10 : 2'b01;
    end
    @(posedge clk_sys);
    {rxMultiframe, rxViolation} <= 2'b00;
  endtask : pulse
  // Bytes qualify only the strobe cycle, then they are inverted
  task automatic send(input logic [4:0] n, input logic [7:0] l, input logic [7:0] b);
    @(posedge clk_sys);
    chanStrobe <= 1'b1;
    chanNum <= n;
    lineRxByte <= l;
    backplaneTransmitInput <= b;
    @(posedge clk_sys);
    chanStrobe <= 1'b0;
    lineRxByte <= ~l;
    backplaneTransmitInput <= ~b;
    #1;
  endtask : send
endmodule : tstec_far_model
